// >>> hdl/cos_contact_output_selector.v
// Contact output selector: three status-driven relay outputs with APB configuration.
// Assumes status inputs on the system clock except the two contact inputs, which are pins.
//
// Added by the designer: the APB register port and the register addresses.
`include "cos_defines.vh"
`default_nettype none

module cos_contact_output_selector #(
  parameter NUM_OUT = 3
) (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_running,
  input wire i_contact_remote_mode,
  input wire i_temp_ready,
  input wire i_stopping_alarm_source,
  input wire i_continuing_alarm,
  input wire i_general_alarm_source,
  input wire i_chosen_alarm,
  input wire i_start_timer_source,
  input wire i_stop_timer_source,
  input wire i_power_recovery_en,
  input wire i_freeze_protect_en,
  input wire i_fluid_filling,
  input wire i_input_one_passthrough,
  input wire i_input_two_passthrough,
  output reg [NUM_OUT-1:0] o_contact_closed
);

  // ****************************************
  // Decoding
  // ****************************************
  function sel_status;
    input [`COS_SRC_W-1:0] src;
    input [13:0] st;
    begin
      case (src)
        `COS_SRC_NONE: sel_status = 1'b0;
        `COS_SRC_RUN: sel_status = st[0];
        `COS_SRC_REMOTE: sel_status = st[1];
        `COS_SRC_TEMP_READY: sel_status = st[2];
        `COS_SRC_STOP_ALARM: sel_status = st[3];
        `COS_SRC_CONT_ALARM: sel_status = st[4];
        `COS_SRC_GEN_ALARM: sel_status = st[5];
        `COS_SRC_SEL_ALARM: sel_status = st[6];
        `COS_SRC_START_TIMER: sel_status = st[7];
        `COS_SRC_STOP_TIMER: sel_status = st[8];
        `COS_SRC_PWR_RECOV: sel_status = st[9];
        `COS_SRC_FREEZE: sel_status = st[10];
        `COS_SRC_INPUT_ONE: sel_status = st[11];
        `COS_SRC_INPUT_TWO: sel_status = st[12];
        `COS_SRC_FILLING: sel_status = st[13];
        default: sel_status = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Contact inputs are external pins; two flops before any use
  reg [1:0] in_meta_ff;
  reg [1:0] in_sync_ff;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_meta_ff <= 2'h0;
      in_sync_ff <= 2'h0;
    end else begin
      in_meta_ff <= {i_input_two_passthrough, i_input_one_passthrough};
      in_sync_ff <= in_meta_ff;
    end
  end

  // Fluid filling is taken regardless of whether filling hardware exists
  wire [13:0] status_vec = {i_fluid_filling, in_sync_ff[1], in_sync_ff[0],
    i_freeze_protect_en, i_power_recovery_en, i_stop_timer_source,
    i_start_timer_source, i_chosen_alarm, i_general_alarm_source,
    i_continuing_alarm, i_stopping_alarm_source, i_temp_ready,
    i_contact_remote_mode, i_running};

  // ****************************************
  // Configuration registers
  // ****************************************
  reg [4:0] cfg_ff [0:NUM_OUT-1];
  wire apb_access = i_psel & i_penable;
  wire apb_wr = apb_access & i_pwrite & i_pstrb[0];
  wire addr_ok = (i_paddr == `COS_REG_CFG1) | (i_paddr == `COS_REG_CFG2) |
    (i_paddr == `COS_REG_CFG3) | (i_paddr == `COS_REG_STATUS);

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out
      wire [31:0] addr_sum = `COS_REG_CFG1 + g * 4;
      wire [11:0] my_addr = addr_sum[11:0];
      wire [`COS_SRC_W-1:0] src = cfg_ff[g][`COS_CFG_SRC_LSB +: `COS_SRC_W];
      wire nc = cfg_ff[g][`COS_CFG_NC_BIT];
      always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          // Defaults of the three documented outputs
          cfg_ff[g] <= (g == 0) ? `COS_CFG1_RST :
            (g == 1) ? `COS_CFG2_RST : `COS_CFG3_RST;
        end else if (apb_wr && !o_pready && i_paddr == my_addr) begin
          cfg_ff[g] <= i_pwdata[4:0];
        end
      end
      // Closed when the polarity-adjusted source is on; open under reset
      always @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_contact_closed[g] <= 1'b0;
        end else begin
          o_contact_closed[g] <= sel_status(src, status_vec) ^ nc;
        end
      end
    end
  endgenerate

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: pready rises at the end of the first access cycle, stays high for one cycle, then drops
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0;
    case (i_paddr)
      `COS_REG_CFG1: nxt_rdata = {27'h0, cfg_ff[0]};
      `COS_REG_CFG2: nxt_rdata = {27'h0, cfg_ff[1]};
      `COS_REG_CFG3: nxt_rdata = {27'h0, cfg_ff[2]};
      `COS_REG_STATUS: nxt_rdata = {29'h0, o_contact_closed};
      default: nxt_rdata = 32'h0;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else if (apb_access && !o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= ~addr_ok;
      o_prdata <= i_pwrite ? 32'h0 : nxt_rdata;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

endmodule // cos_contact_output_selector

`default_nettype wire

// >>> hdl/cos_defines.vh
// Constants of the contact output selector: source codes, register map, reset values.
// Assumes inclusion by the selector module only, on a 20 MHz system clock.
//
// Operation
// - Exactly three independent contact outputs, each closed or open.
// - Defaults: out1 run normally-open, out2 remote normally-open, out3 alarm normally-closed.
// - Each output has selectable source and polarity; normally-closed inverts the result.
// - Asserted output closes its contact; closed means on, open means off.
// - Source none: open when normally-open, closed when normally-closed.
// - Run source: on while the product operates.
// - Remote source: on in contact remote mode, off in contact local mode.
// - Temperature ready source: on once preparation temperature is reached.
// - Stopping alarm source: on while an operation halting alarm is present.
// - Continuing alarm source: on while an alarm that lets operation continue is present.
// - General alarm source: on while any alarm is present.
// - Chosen alarm source: on while the selected alarm is raised.
// - Start timer source: on while an operation start timer is set.
// - Stop timer source: on while an operation stop timer is set.
// - Power recovery source: on while automatic restart after power loss is enabled.
// - Freeze protection source: on while anti-freezing is enabled.
// - Pass-through sources copy contact input 1 or 2, complemented when normally-closed.
// - Fluid filling source: on while automatic filling is in progress.
// - Fluid filling output follows its source even without filling hardware fitted.
`ifndef COS_DEFINES_VH
`define COS_DEFINES_VH

// Source select codes
`define COS_SRC_W 4
`define COS_SRC_NONE 4'h0
`define COS_SRC_RUN 4'h1
`define COS_SRC_REMOTE 4'h2
`define COS_SRC_TEMP_READY 4'h3
`define COS_SRC_STOP_ALARM 4'h4
`define COS_SRC_CONT_ALARM 4'h5
`define COS_SRC_GEN_ALARM 4'h6
`define COS_SRC_SEL_ALARM 4'h7
`define COS_SRC_START_TIMER 4'h8
`define COS_SRC_STOP_TIMER 4'h9
`define COS_SRC_PWR_RECOV 4'ha
`define COS_SRC_FREEZE 4'hb
`define COS_SRC_INPUT_ONE 4'hc
`define COS_SRC_INPUT_TWO 4'hd
`define COS_SRC_FILLING 4'he

// Register byte offsets
`define COS_REG_CFG1 12'h000
`define COS_REG_CFG2 12'h004
`define COS_REG_CFG3 12'h008
`define COS_REG_STATUS 12'h00c

// Configuration field layout: source in [3:0], normally-closed flag in bit 4
`define COS_CFG_SRC_LSB 0
`define COS_CFG_NC_BIT 4

// Reset values of the configuration registers
`define COS_CFG1_RST 5'h01
`define COS_CFG2_RST 5'h02
`define COS_CFG3_RST 5'h16

`endif

// >>> testbench/cos_checker.sv
// Checker: APB answer timing and contact reset state.
// Assumes binding into the selector.
`default_nettype none
module cos_checker #(parameter int NUM_OUT = 3) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NUM_OUT-1:0] o_contact_closed);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_open; $fell(i_sys_rst) |-> o_contact_closed == '0; endproperty
  a_open: assert property (p_open) else $error("closed in reset");
  property p_ans; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_idle; !(i_psel && i_penable) |=> !o_pready; endproperty
  a_idle: assert property (p_idle) else $error("idle ready");
  property p_acc; o_pready |-> i_psel && i_penable; endproperty
  a_acc: assert property (p_acc) else $error("stray ready");
  property p_wait; o_pready |-> $past(i_penable); endproperty
  a_wait: assert property (p_wait) else $error("no wait");
  property p_eonly; o_pslverr |-> o_pready; endproperty
  a_eonly: assert property (p_eonly) else $error("lone error");
  property p_quiet; !i_psel |=> !o_pslverr; endproperty
  a_quiet: assert property (p_quiet) else $error("idle error");
endmodule // cos_checker
bind cos_contact_output_selector cos_checker #(.NUM_OUT(NUM_OUT)) chk (.i_sys_clk,
  .i_sys_rst, .i_psel, .i_penable, .o_pready, .o_pslverr, .o_contact_closed);
`default_nettype wire

// >>> testbench/cos_cust.sv
// Customer equipment sensing the relay contacts.
// Assumes a closed contact reads high.
`default_nettype none
module cos_cust #(parameter int NUM_OUT = 3) (
  input wire logic [NUM_OUT-1:0] i_closed,
  output logic [NUM_OUT-1:0] o_on);
  timeunit 1ns / 1ns;
  assign o_on = i_closed;
endmodule // cos_cust
`default_nettype wire

// >>> testbench/tb.sv
// Bench: APB tasks and source sweeps.
// Assumes the selector, its checker and the customer model.
`default_nettype none
module tb;
  timeunit 1ns / 1ns;
  logic clk = 1'b0, rst, psel, pen, pwr, pr, pe, err;
  logic [11:0] pa;
  logic [31:0] pw, prd, rd;
  logic [13:0] st;
  logic [3:0] ps;
  logic [2:0] cc, on;
  int failures, checks_done;
  cos_contact_output_selector DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pw), .i_pstrb(ps), .o_prdata(prd),
    .o_pready(pr), .o_pslverr(pe), .i_running(st[0]), .i_contact_remote_mode(st[1]),
    .i_temp_ready(st[2]), .i_stopping_alarm_source(st[3]), .i_continuing_alarm(st[4]),
    .i_general_alarm_source(st[5]), .i_chosen_alarm(st[6]), .i_start_timer_source(st[7]),
    .i_stop_timer_source(st[8]), .i_power_recovery_en(st[9]), .i_freeze_protect_en(st[10]),
    .i_input_one_passthrough(st[11]), .i_input_two_passthrough(st[12]),
    .i_fluid_filling(st[13]), .o_contact_closed(cc));
  cos_cust cust (.i_closed(cc), .o_on(on));
  initial forever #25 clk = ~clk;
  task automatic ck(input logic ok);
    checks_done++;
    if (ok !== 1'b1) $display("[ERR] %0t bad %0d", $time, ++failures);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, pa, pw} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pr !== 1'b1);
    {rd, err} = {prd, pe};
    {psel, pen} <= 2'b0;
  endtask
  task automatic stop_test(input int late);
    failures += late;
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #500000;
    $display("[ERR] %0t timeout", $time);
    stop_test(1);
  end
  initial begin
    {rst, psel, pen, pwr, pa, pw, st} = {1'b1, 61'h0};
    ps = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ck(on === 3'b100);
    apb(0, 12'h008, 0);
    ck(rd === 32'h16);
    apb(0, 12'h010, 0);
    ck(err === 1'b1);
    // Byte lane 0 off: the write must not touch output 1's setting
    ps <= 4'h0;
    apb(1, 12'h000, 32'h0000000e);
    ps <= 4'hf;
    apb(0, 12'h000, 0);
    ck(rd === 32'h1);
    // Source sweep: every code, both polarities, selected input high then low
    for (int i = 0; i < 192; i++) begin
      logic exp;
      apb(1, {8'h0, i[7:6], 2'b0}, {27'h0, i[0], i[5:2]});
      st <= i[1] ? ~(14'h1 << (i[5:2] - 1)) : 14'h1 << (i[5:2] - 1);
      exp = (i[5:2] inside {0, 15}) ? i[0] : !(i[1] ^ i[0]);
      repeat (5) @(posedge clk);
      ck(on[i[7:6]] === exp);
    end
    apb(0, 12'h00c, 0);
    ck(rd === 32'h7);
    // Mid-run reset: contacts open while held, defaults back after release
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    ck(on === 3'b000);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ck(on === 3'b011);
    apb(0, 12'h000, 0);
    ck(rd === 32'h1);
    stop_test(0);
  end
endmodule // tb
`default_nettype wire
